// ### ebtm_core.sv
// Emulator break control, trace, run counter and memory map
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ebtm_core
   import ebtm_pkg::*;
#(
   parameter logic [15:0] TRAP_OPCODE = 16'h0000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic cpu_valid_i,
   input wire logic [23:0] cpu_addr_i,
   input wire logic [15:0] cpu_data_i,
   input wire logic cpu_we_i,
   input wire logic [3:0] cpu_status_i,
   input wire logic cpu_fetch_i,
   input wire logic cpu_insn_done_i,
   input wire logic cpu_trap_i,
   input wire logic [23:0] rst_vector_i,
   output logic cpu_run_o,
   output logic irq_mask_o,
   output logic sub_en_o,
   output logic [15:0] sub_data_o,
   output logic [1:0] map_target_o,
   output logic [1:0] map_access_o,
   output logic cpu_load_o,
   output logic [23:0] load_pc_o,
   output logic [23:0] load_sp_o,
   output logic [31:0] load_gr_o,
   output logic [7:0] load_ccr_o,
   output logic [7:0] load_exr_o,
   output logic mcu_rst_o,
   output logic acc_req_o,
   output logic acc_space_o,
   output logic acc_we_o,
   output logic [1:0] acc_size_o,
   output logic [23:0] acc_addr_o,
   output logic [31:0] acc_wdata_o,
   input wire logic [31:0] acc_rdata_i,
   input wire logic acc_done_i
);

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] sel);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // Masked factors count as met; all factors ANDed
   function automatic logic cmp_match(input logic [31:0] a,
      input logic [31:0] c, input logic [23:0] addr,
      input logic [15:0] data, input logic we);
      logic ok;
      ok = c[CF_EN];
      ok = ok & (c[CF_MA] | (addr == a[23:0]));
      ok = ok & (c[CF_MD] | (data == c[15:0]));
      ok = ok & (c[CF_MRW] | (we == c[CF_RW]));
      return ok;
   endfunction : cmp_match

   ebtm_regs_s s;
   ebtm_regs_s n;
   logic [TR_W-1:0] tr_mem [2**TR_AW];
   logic [NCMP-1:0] cmp_hit;
   logic running;
   logic req;
   logic wr;
   logic wr_ctrl;
   logic rt_clr;
   logic tr_we;
   logic [3:0] ma;
   logic hit;
   logic [2:0] hit_cause;
   logic [TR_AW-1:0] tr_ra;
   logic [TR_W-1:0] tr_rd;
   logic [6:0] frac_sum;

   assign running = (s.st != ST_BRK);
   assign req = wb_cyc_i & wb_stb_i & ~s.ack;
   assign wr = req & wb_we_i;
   assign wr_ctrl = wr & (wb_adr_i == OFS_CTRL) & wb_sel_i[0];
   assign rt_clr = wr & (wb_adr_i == OFS_RTLO);

   // -------------------------------------------------------------
   // Comparators
   // -------------------------------------------------------------
   for (genvar g = 0; g < NCMP; g++) begin : g_cmp
      // Event comparators never look at data
      localparam logic [31:0] FORCE = (g < NEV) ? (32'h1 << CF_MD) : 32'h0;
      assign cmp_hit[g] = cmp_match(s.cmp_a[g], s.cmp_c[g] | FORCE,
         cpu_addr_i, cpu_data_i, cpu_we_i);
   end

   // -------------------------------------------------------------
   // Memory map lookup
   // -------------------------------------------------------------
   always_comb begin
      ma = ATTR_DEF;
      for (int i = NMAP - 1; i >= 0; i--) begin
         if (cpu_addr_i[23:BLK_LSB] >= s.map_lo[i][23:BLK_LSB] &&
             cpu_addr_i[23:BLK_LSB] <= s.map_hi[i][23:BLK_LSB]) begin
            ma = s.map_hi[i][27:24];
         end
      end
   end

   assign map_target_o = ma[3:2];
   assign map_access_o = ma[1:0];

   // -------------------------------------------------------------
   // Break sources seen on this bus cycle
   // -------------------------------------------------------------
   always_comb begin
      hit = 1'b0;
      hit_cause = BC_NONE;
      if (running && cpu_valid_i) begin
         if (ma[1:0] == AM_GRD) begin
            hit = 1'b1;
            hit_cause = BC_GUARD;
         end else if (cpu_we_i && ma[1:0] == AM_RO) begin
            hit = 1'b1;
            hit_cause = BC_WPROT;
         end else if (|cmp_hit[NEV-1:0]) begin
            hit = 1'b1;
            hit_cause = BC_EVENT;
         end else if (|cmp_hit[NCMP-1:NEV]) begin
            hit = 1'b1;
            hit_cause = BC_SLOT;
         end
      end
   end

   assign tr_we = running & cpu_valid_i;
   assign tr_ra = s.tr_full ? TR_AW'(s.tr_wp + s.tr_idx) : s.tr_idx;
   assign tr_rd = tr_mem[tr_ra];
   assign frac_sum = {1'b0, s.frac} + {1'b0, RT_INC};

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      n = s;
      n.ack = req;
      n.load = 1'b0;
      n.mrst = s.load;

      // Run counter, frozen in break
      if (running) begin
         if (frac_sum >= {1'b0, RT_RES}) begin
            n.frac = 6'(frac_sum - {1'b0, RT_RES});
            n.rt = s.rt + 64'h1;
         end else begin
            n.frac = frac_sum[5:0];
         end
      end
      if (rt_clr) begin
         n.rt = 64'h0;
         n.frac = 6'h0;
      end

      // Trace write pointer
      if (tr_we) begin
         n.tr_wp = TR_AW'(s.tr_wp + 1'b1);
         if (s.tr_wp == {TR_AW{1'b1}}) begin
            n.tr_full = 1'b1;
         end
      end

      // Pending hardware breaks
      if (hit && !s.pend) begin
         n.pend = 1'b1;
         n.pcause = hit_cause;
      end

      // Host access completion
      if (s.acc_req && acc_done_i) begin
         n.acc_req = 1'b0;
         n.acc_rd = acc_rdata_i;
      end

      // Run control
      case (s.st)
         ST_BRK: begin
            if (wr_ctrl && wb_dat_i[CMD_GO]) begin
               n.st = ST_RUN;
               n.cause = BC_NONE;
            end else if (wr_ctrl && wb_dat_i[CMD_STEP]) begin
               n.st = ST_STEP;
               n.cause = BC_NONE;
            end else if (wr_ctrl && wb_dat_i[CMD_RST]) begin
               n.load = 1'b1;
               n.lpc = rst_vector_i;
            end
         end
         ST_RUN, ST_STEP: begin
            if (wr_ctrl && wb_dat_i[CMD_BRK]) begin
               n.st = ST_BRK;
               n.cause = BC_USER;
            end else if (cpu_trap_i) begin
               n.st = ST_BRK;
               n.cause = BC_PC;
            end else if (cpu_insn_done_i && (s.pend || hit)) begin
               n.st = ST_BRK;
               n.cause = s.pend ? s.pcause : hit_cause;
            end else if (cpu_insn_done_i && s.st == ST_STEP) begin
               n.st = ST_BRK;
               n.cause = BC_NONE;
            end
            if (n.st == ST_BRK) begin
               n.pend = 1'b0;
            end
         end
         default: n.st = ST_BRK;
      endcase

      // Host access start, break mode only
      if (wr_ctrl && wb_dat_i[CMD_ACC]) begin
         if (running || s.acc_req || s.acc_c[1:0] > SZ_LONG) begin
            n.acc_err = 1'b1;
         end else begin
            n.acc_req = 1'b1;
            n.acc_err = 1'b0;
         end
      end

      // Register writes
      if (wr) begin
         case (wb_adr_i)
            OFS_PCBP: n.pcbp = merge(s.pcbp, wb_dat_i, wb_sel_i);
            OFS_TRIX: n.tr_idx = wb_sel_i[0] ? wb_dat_i[TR_AW-1:0] :
               s.tr_idx;
            OFS_ACCA: n.acc_a = merge(s.acc_a, wb_dat_i, wb_sel_i);
            OFS_ACCW: n.acc_wd = merge(s.acc_wd, wb_dat_i, wb_sel_i);
            OFS_ACCC: n.acc_c = merge(s.acc_c, wb_dat_i, wb_sel_i);
            default: ;
         endcase
         for (int i = 0; i < NCMP; i++) begin
            if (wb_adr_i == OFS_CMP + 8'(8 * i)) begin
               n.cmp_a[i] = merge(s.cmp_a[i], wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == OFS_CMP + 8'(8 * i + 4)) begin
               n.cmp_c[i] = merge(s.cmp_c[i], wb_dat_i, wb_sel_i);
            end
         end
         for (int i = 0; i < NMAP; i++) begin
            if (wb_adr_i == OFS_MAP + 8'(8 * i)) begin
               n.map_lo[i] = merge(s.map_lo[i], wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == OFS_MAP + 8'(8 * i + 4)) begin
               n.map_hi[i] = merge(s.map_hi[i], wb_dat_i, wb_sel_i);
            end
         end
      end

      // Read data, unmapped reads return zero
      n.dat = 32'h0;
      if (req && !wb_we_i) begin
         case (wb_adr_i)
            OFS_STAT: n.dat = {21'h0, s.tr_full, s.acc_err, s.acc_req,
               2'h0, s.pend, s.cause, s.st == ST_STEP, s.st == ST_BRK};
            OFS_PCBP: n.dat = s.pcbp;
            OFS_RTLO: n.dat = s.rt[31:0];
            OFS_RTHI: n.dat = s.rt[63:32];
            OFS_TRIX: n.dat = {23'h0, s.tr_full, s.tr_wp};
            OFS_TRA: n.dat = {tr_rd[44:40], 3'h0, tr_rd[23:0]};
            OFS_TRD: n.dat = {16'h0, tr_rd[39:24]};
            OFS_ACCA: n.dat = s.acc_a;
            OFS_ACCW: n.dat = s.acc_wd;
            OFS_ACCC: n.dat = s.acc_c;
            OFS_ACCR: n.dat = s.acc_rd;
            default: ;
         endcase
         for (int i = 0; i < NCMP; i++) begin
            if (wb_adr_i == OFS_CMP + 8'(8 * i)) begin
               n.dat = s.cmp_a[i];
            end
            if (wb_adr_i == OFS_CMP + 8'(8 * i + 4)) begin
               n.dat = s.cmp_c[i];
            end
         end
         for (int i = 0; i < NMAP; i++) begin
            if (wb_adr_i == OFS_MAP + 8'(8 * i)) begin
               n.dat = s.map_lo[i];
            end
            if (wb_adr_i == OFS_MAP + 8'(8 * i + 4)) begin
               n.dat = s.map_hi[i];
            end
         end
      end
   end

   // -------------------------------------------------------------
   // State registers
   // -------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.map_lo <= {NMAP{MAP_LO_RST}};
      end else begin
         s <= n;
      end
   end

   // Trace buffer, one entry per bus cycle
   always_ff @(posedge clk_i) begin
      if (tr_we) begin
         tr_mem[s.tr_wp] <= {cpu_status_i, cpu_we_i, cpu_data_i,
            cpu_addr_i};
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign wb_dat_o = s.dat;
   assign wb_ack_o = s.ack;
   assign cpu_run_o = running;
   assign irq_mask_o = (s.st != ST_RUN);
   assign sub_en_o = running & s.pcbp[CF_EN] & cpu_fetch_i &
      (cpu_addr_i == s.pcbp[23:0]);
   assign sub_data_o = TRAP_OPCODE;
   assign cpu_load_o = s.load;
   assign load_pc_o = s.lpc;
   assign load_sp_o = RST_SP;
   assign load_gr_o = RST_GR;
   assign load_ccr_o = RST_CCR;
   assign load_exr_o = RST_EXR;
   assign mcu_rst_o = s.mrst;
   assign acc_req_o = s.acc_req;
   assign acc_space_o = s.acc_c[AC_SPACE];
   assign acc_we_o = s.acc_c[AC_WE];
   assign acc_size_o = s.acc_c[1:0];
   assign acc_addr_o = s.acc_a[23:0];
   assign acc_wdata_o = s.acc_wd;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_reset_load: assert property (
      wr_ctrl && wb_dat_i[CMD_RST] && !wb_dat_i[CMD_GO] &&
      !wb_dat_i[CMD_STEP] && !running |=> cpu_load_o &&
      load_pc_o == $past(rst_vector_i) ##1 mcu_rst_o)
      else $error("cpu reset load sequence wrong");
   chk_no_steal: assert property (acc_req_o |-> !cpu_run_o)
      else $error("host access while running");
   chk_event_end: assert property (
      $fell(cpu_run_o) && (s.cause == BC_EVENT || s.cause == BC_SLOT)
      |-> $past(cpu_insn_done_i))
      else $error("event break before instruction end");
   chk_trap_stop: assert property (
      running && cpu_trap_i |=> !cpu_run_o && s.cause != BC_NONE)
      else $error("trap did not stop");
   chk_guard_pend: assert property (
      running && cpu_valid_i && map_access_o == AM_GRD &&
      !cpu_insn_done_i |=> s.pend)
      else $error("guarded access not caught");
   chk_wprot_pend: assert property (
      running && cpu_valid_i && cpu_we_i && map_access_o == AM_RO &&
      !cpu_insn_done_i |=> s.pend)
      else $error("read-only write not caught");
   chk_force_brk: assert property (
      running && wr_ctrl && wb_dat_i[CMD_BRK] |=> !cpu_run_o &&
      s.cause == BC_USER)
      else $error("forced break missed");
   chk_rt_rate: assert property (
      (running && !rt_clr) [*5] ##1 1'b1 |->
      s.rt == $past(s.rt, 5) + 64'h2)
      else $error("run counter rate wrong");
   chk_irq_step: assert property (
      s.st == ST_STEP |-> irq_mask_o)
      else $error("interrupt open while stepping");
   chk_step_one: assert property (
      s.st == ST_STEP && cpu_insn_done_i |=> s.st == ST_BRK)
      else $error("step ran on");
   chk_acc_refuse: assert property (
      running && wr_ctrl && wb_dat_i[CMD_ACC] |=> s.acc_err)
      else $error("access in run not refused");
   chk_freeze: assert property (
      !running && !rt_clr && !tr_we |=> $stable(s.rt) &&
      $stable(s.tr_wp))
      else $error("counter or trace moved in break");
endmodule : ebtm_core
`default_nettype wire

// ### ebtm_pkg.sv
// Constants and types of the emulator break, trace and map block
// What this block does
// - CPU reset loads vector, stack, flags
// - No host access starts while running; one issued in break or with go continues in run
// - Event break waits for instruction end
// - PC break stops before the instruction
// - Trap opcode substituted at PC breakpoint
// - Guarded area access raises a break
// - Write to read-only area raises break
// - Host forced break halts at once
// - Two event comparators, address and direction
// - Two slot comparators add data value
// - Run counter ticks 50 ns, frozen in break
// - Trace keeps last 256 bus cycles
// - Entry: address, data, direction, status
// - Map routes accesses per 32-byte block
// - Nine attributes: three targets, three modes
// - Unmapped space defaults to external guarded
// - Interrupts held off while stepping
// - Step runs one instruction then breaks
// - Register access in run and break mode
// - Host access in byte, word, long
package ebtm_pkg;
   typedef enum logic [1:0] {ST_BRK, ST_RUN, ST_STEP} ebtm_state_e;

   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_PCBP = 8'h08;
   localparam logic [7:0] OFS_CMP = 8'h10;
   localparam logic [7:0] OFS_RTLO = 8'h30;
   localparam logic [7:0] OFS_RTHI = 8'h34;
   localparam logic [7:0] OFS_TRIX = 8'h38;
   localparam logic [7:0] OFS_TRA = 8'h3c;
   localparam logic [7:0] OFS_TRD = 8'h40;
   localparam logic [7:0] OFS_ACCA = 8'h44;
   localparam logic [7:0] OFS_ACCW = 8'h48;
   localparam logic [7:0] OFS_ACCC = 8'h4c;
   localparam logic [7:0] OFS_ACCR = 8'h50;
   localparam logic [7:0] OFS_MAP = 8'h60;

   // -------------------------------------------------------------
   // Fields, sizes and reset values
   // -------------------------------------------------------------
   localparam int CMD_GO = 0;
   localparam int CMD_STEP = 1;
   localparam int CMD_BRK = 2;
   localparam int CMD_RST = 3;
   localparam int CMD_ACC = 4;
   localparam int CF_RW = 16;
   localparam int CF_MA = 17;
   localparam int CF_MD = 18;
   localparam int CF_MRW = 19;
   localparam int CF_EN = 31;
   localparam int AC_SPACE = 3;
   localparam int AC_WE = 2;
   localparam int NCMP = 4;
   localparam int NEV = 2;
   localparam int NMAP = 4;
   localparam int BLK_LSB = 5;
   localparam int TR_AW = 8;
   localparam int TR_W = 45;
   localparam logic [23:0] RST_SP = 24'hffefbc;
   localparam logic [31:0] RST_GR = 32'h0000_0000;
   localparam logic [7:0] RST_CCR = 8'h80;
   localparam logic [7:0] RST_EXR = 8'h07;
   localparam logic [31:0] MAP_LO_RST = 32'h00ff_ffff;
   localparam logic [1:0] SZ_LONG = 2'h2;

   // Attribute: [3:2] target, [1:0] access mode
   localparam logic [1:0] TG_CHIP = 2'h0;
   localparam logic [1:0] TG_EMU = 2'h1;
   localparam logic [1:0] TG_EXT = 2'h2;
   localparam logic [1:0] AM_RW = 2'h0;
   localparam logic [1:0] AM_RO = 2'h1;
   localparam logic [1:0] AM_GRD = 2'h2;
   localparam logic [3:0] ATTR_DEF = {TG_EXT, AM_GRD};

   // Break causes
   localparam logic [2:0] BC_NONE = 3'h0;
   localparam logic [2:0] BC_EVENT = 3'h1;
   localparam logic [2:0] BC_SLOT = 3'h2;
   localparam logic [2:0] BC_PC = 3'h3;
   localparam logic [2:0] BC_USER = 3'h4;
   localparam logic [2:0] BC_GUARD = 3'h5;
   localparam logic [2:0] BC_WPROT = 3'h6;

   // Run counter timing
   localparam int CLK_NS = 20;
   localparam int RT_RES_NS = 50;
   localparam logic [5:0] RT_INC = 6'(CLK_NS);
   localparam logic [5:0] RT_RES = 6'(RT_RES_NS);

   typedef struct packed {
      ebtm_state_e st;
      logic [2:0] cause;
      logic pend;
      logic [2:0] pcause;
      logic [31:0] pcbp;
      logic [NCMP-1:0][31:0] cmp_a;
      logic [NCMP-1:0][31:0] cmp_c;
      logic [NMAP-1:0][31:0] map_lo;
      logic [NMAP-1:0][31:0] map_hi;
      logic [63:0] rt;
      logic [5:0] frac;
      logic [TR_AW-1:0] tr_wp;
      logic tr_full;
      logic [TR_AW-1:0] tr_idx;
      logic [31:0] acc_a;
      logic [31:0] acc_wd;
      logic [31:0] acc_c;
      logic [31:0] acc_rd;
      logic acc_req;
      logic acc_err;
      logic ack;
      logic [31:0] dat;
      logic load;
      logic [23:0] lpc;
      logic mrst;
   } ebtm_regs_s;
endpackage : ebtm_pkg

// ### ebtm_cpu_model.sv
// Behavioural target CPU bus and host access partner
`timescale 1ns/1ps
`default_nettype none
module ebtm_cpu_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic sub_en_i,
   input wire logic we_i,
   input wire logic [23:0] base_i,
   input wire logic acc_req_i,
   input wire logic [3:0] dly_i,
   output logic valid_o,
   output logic [23:0] addr_o,
   output logic [15:0] data_o,
   output logic cpu_we_o,
   output logic [3:0] status_o,
   output logic fetch_o,
   output logic done_o,
   output logic trap_o,
   output logic [31:0] rdata_o,
   output logic acc_done_o
);
   localparam logic [31:0] ACC_RD = 32'h5a5a_0f0f;
   logic [23:0] pc;
   logic [3:0] wait_cnt;
   logic served;
   // ------------------------------------------------------------
   // Target bus: two-cycle instructions, done on the second
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      trap_o <= valid_o & fetch_o & sub_en_i;
      valid_o <= 1'b0;
      fetch_o <= 1'b0;
      done_o <= 1'b0;
      pc <= base_i;
      if (rst_i) begin
         addr_o <= 24'h0;
         data_o <= 16'h0;
         cpu_we_o <= 1'b0;
         status_o <= 4'h0;
      end else if (!run_i) begin
         // Idle bus shows no stale cycle
         addr_o <= ~addr_o;
         data_o <= ~data_o;
         cpu_we_o <= ~cpu_we_o;
         status_o <= ~status_o;
      end else begin
         valid_o <= 1'b1;
         fetch_o <= ~we_i;
         done_o <= valid_o & ~done_o;
         addr_o <= pc;
         data_o <= pc[15:0];
         cpu_we_o <= we_i;
         status_o <= 4'h5;
         pc <= pc + 24'h2;
      end
   end
   // Host access answered after a chosen delay
   always_ff @(posedge clk_i) begin
      acc_done_o <= 1'b0;
      if (rst_i || !acc_req_i) begin
         wait_cnt <= 4'h0;
         served <= 1'b0;
      end else if (!served) begin
         wait_cnt <= wait_cnt + 4'h1;
         if (wait_cnt == dly_i) begin
            acc_done_o <= 1'b1;
            served <= 1'b1;
         end
      end
   end
   assign rdata_o = acc_done_o ? ACC_RD : ~ACC_RD;
endmodule : ebtm_cpu_model
`default_nettype wire

// ### ebtm_core_tb.sv
// Self-checking bench of the emulator break, trace and map block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module ebtm_core_tb;
   import ebtm_pkg::*;
   localparam logic [23:0] VEC = 24'h000400;
   localparam logic [7:0] C_O1 [5] = '{OFS_MAP, OFS_MAP, OFS_CMP,
      OFS_CMP + 8'h10, OFS_PCBP};
   localparam logic [7:0] C_O2 [5] = '{OFS_MAP + 8'h4, OFS_MAP + 8'h4,
      OFS_CMP + 8'h4, OFS_CMP + 8'h14, OFS_PCBP};
   localparam logic [31:0] C_D1 [5] = '{32'h1000, 32'h1000, 32'h2004,
      32'h3004, 32'h8000_4006};
   localparam logic [31:0] C_D2 [5] = '{{4'h0, TG_CHIP, AM_GRD, 24'h00101f},
      {4'h0, TG_EMU, AM_RO, 24'h00101f}, 32'h8008_0000, 32'h8000_3004,
      32'h8000_4006};
   localparam logic [23:0] C_BASE [5] = '{24'h1000, 24'h1000, 24'h2000,
      24'h3000, 24'h4000};
   localparam logic C_WE [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   localparam logic [2:0] C_CAUSE [5] = '{BC_GUARD, BC_WPROT, BC_EVENT,
      BC_SLOT, BC_PC};
   int err_total = 0;
   int cmp_count = 0;
   int ld_cnt = 0;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, run_we, ld_d, rs_ok;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i, rd, r1;
   logic [23:0] base;
   logic [3:0] dly;
   wire logic [3:0] wb_sel_i = 4'hf;
   wire logic [23:0] rst_vector_i = VEC;
   wire logic wb_ack_o, cpu_valid_i, cpu_we_i, cpu_fetch_i, cpu_insn_done_i;
   wire logic cpu_trap_i, cpu_run_o, irq_mask_o, sub_en_o, cpu_load_o;
   wire logic mcu_rst_o, acc_req_o, acc_space_o, acc_we_o, acc_done_i;
   wire logic [1:0] map_target_o, map_access_o, acc_size_o;
   wire logic [3:0] cpu_status_i;
   wire logic [7:0] load_ccr_o, load_exr_o;
   wire logic [15:0] cpu_data_i, sub_data_o;
   wire logic [23:0] cpu_addr_i, load_pc_o, load_sp_o, acc_addr_o;
   wire logic [31:0] wb_dat_o, acc_rdata_i, acc_wdata_o, load_gr_o;
   ebtm_core u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cpu_valid_i,
      .cpu_addr_i, .cpu_data_i, .cpu_we_i, .cpu_status_i, .cpu_fetch_i,
      .cpu_insn_done_i, .cpu_trap_i, .rst_vector_i, .cpu_run_o, .irq_mask_o,
      .sub_en_o, .sub_data_o, .map_target_o, .map_access_o, .cpu_load_o,
      .load_pc_o, .load_sp_o, .load_gr_o, .load_ccr_o, .load_exr_o,
      .mcu_rst_o, .acc_req_o, .acc_space_o, .acc_we_o, .acc_size_o,
      .acc_addr_o, .acc_wdata_o, .acc_rdata_i, .acc_done_i);
   ebtm_cpu_model u_cpu (.clk_i, .rst_i, .run_i(cpu_run_o),
      .sub_en_i(sub_en_o), .we_i(run_we), .base_i(base),
      .acc_req_i(acc_req_o), .dly_i(dly), .valid_o(cpu_valid_i),
      .addr_o(cpu_addr_i), .data_o(cpu_data_i), .cpu_we_o(cpu_we_i),
      .status_o(cpu_status_i), .fetch_o(cpu_fetch_i),
      .done_o(cpu_insn_done_i), .trap_o(cpu_trap_i), .rdata_o(acc_rdata_i),
      .acc_done_o(acc_done_i));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Reset pulse order: load first, then target reset
   always @(posedge clk_i) begin
      ld_d <= cpu_load_o;
      if (cpu_load_o === 1'b1) ld_cnt <= ld_cnt + 1;
      if (mcu_rst_o === 1'b1) rs_ok <= (ld_d === 1'b1);
   end
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      `CHK("wb_ack", 1'b1, wb_ack_o)
   endtask : wb
   task automatic wait_run(input logic v, input int lim);
      for (int n = 0; n < lim && cpu_run_o !== v; n++) @(posedge clk_i);
      `CHK("cpu_run", v, cpu_run_o)
   endtask : wait_run
   initial begin
      #400000;
      err_total++;
      summarize();
   end
   initial begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, run_we, ld_d, rs_ok} = 6'h0;
      wb_adr_i = 8'h0;
      wb_dat_i = 32'h0;
      base = 24'h0;
      dly = 4'h0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, OFS_STAT, 32'h0);
      `CHK("stat_rst", 32'h1, rd)
      `CHK("tgt_rst", TG_EXT, map_target_o)
      `CHK("acc_rst", AM_GRD, map_access_o)
      wb(1'b0, OFS_MAP, 32'h0);
      `CHK("map_lo", MAP_LO_RST, rd)
      wb(1'b0, 8'hfc, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      wb(1'b1, OFS_MAP + 8'h8, 32'h0);
      wb(1'b1, OFS_MAP + 8'hc, {4'h0, TG_EXT, AM_RW, 24'hffffff});
      `CHK("map_rw", AM_RW, map_access_o)
      wb(1'b1, OFS_CTRL, 32'h8);
      repeat (4) @(posedge clk_i);
      `CHK("load_cnt", 1, ld_cnt)
      `CHK("mcu_rst", 1'b1, rs_ok)
      `CHK("pc", VEC, load_pc_o)
      `CHK("sp", 24'hffefbc, load_sp_o)
      `CHK("gr", 32'h0, load_gr_o)
      `CHK("ccr", 8'h80, load_ccr_o)
      `CHK("exr", 8'h07, load_exr_o)
      $display("Test reset and cpu reset done");
      base <= 24'h005000;
      wb(1'b1, OFS_CTRL, 32'h1);
      wait_run(1'b1, 5);
      `CHK("irq_run", 1'b0, irq_mask_o)
      wb(1'b1, OFS_ACCC, 32'ha);
      wb(1'b1, OFS_CTRL, 32'h10);
      wb(1'b0, OFS_STAT, 32'h0);
      `CHK("acc_err", 1'b1, rd[9])
      `CHK("acc_req", 1'b0, acc_req_o)
      `CHK("run_kept", 1'b1, cpu_run_o)
      wb(1'b1, OFS_CTRL, 32'h4);
      wait_run(1'b0, 3);
      wb(1'b0, OFS_STAT, 32'h0);
      `CHK("user_cause", {BC_USER, 2'b01}, rd[4:0])
      wb(1'b0, OFS_RTLO, 32'h0);
      r1 = rd;
      `CHK("rt_runs", 1'b1, r1 != 32'h0)
      repeat (20) @(posedge clk_i);
      wb(1'b0, OFS_RTLO, 32'h0);
      `CHK("rt_frozen", r1, rd)
      wb(1'b1, OFS_RTLO, 32'h0);
      wb(1'b0, OFS_RTLO, 32'h0);
      `CHK("rt_clear", 32'h0, rd)
      wb(1'b1, OFS_TRIX, 32'h0);
      wb(1'b0, OFS_TRA, 32'h0);
      `CHK("tr_addr", {4'h5, 4'h0, 24'h005000}, rd)
      wb(1'b0, OFS_TRD, 32'h0);
      `CHK("tr_data", 32'h5000, rd)
      wb(1'b0, OFS_TRIX, 32'h0);
      `CHK("tr_full", 1'b0, rd[8])
      $display("Test force break and trace done");
      for (int i = 0; i < 5; i++) begin
         base <= C_BASE[i];
         run_we <= C_WE[i];
         wb(1'b1, C_O1[i], C_D1[i]);
         wb(1'b1, C_O2[i], C_D2[i]);
         wb(1'b1, OFS_CTRL, 32'h1);
         wait_run(1'b1, 5);
         wait_run(1'b0, 60);
         wb(1'b0, OFS_STAT, 32'h0);
         `CHK("cause", {C_CAUSE[i], 2'b01}, rd[4:0])
         wb(1'b1, C_O1[i], 32'h0);
         wb(1'b1, C_O2[i], 32'h0);
         $display("Test break case %0d done", i);
      end
      run_we <= 1'b0;
      wb(1'b1, OFS_CTRL, 32'h2);
      wait_run(1'b1, 5);
      `CHK("irq_step", 1'b1, irq_mask_o)
      wait_run(1'b0, 5);
      $display("Test step done");
      wb(1'b1, OFS_ACCA, 32'h0012_3456);
      wb(1'b1, OFS_ACCW, 32'hcafe_0001);
      for (int s = 0; s < 3; s++) begin
         dly <= (s == 1) ? 4'h6 : 4'h0;
         wb(1'b1, OFS_ACCC, 32'(s) | ((s == 0) ? 32'h4 : 32'h8));
         wb(1'b1, OFS_CTRL, 32'h10);
         for (int n = 0; n < 20 && acc_req_o !== 1'b1; n++) @(posedge clk_i);
         `CHK("acc_size", 2'(s), acc_size_o)
         `CHK("acc_we", s == 0, acc_we_o)
         `CHK("acc_space", s != 0, acc_space_o)
         `CHK("acc_addr", 24'h123456, acc_addr_o)
         for (int n = 0; n < 20 && acc_req_o !== 1'b0; n++) @(posedge clk_i);
         wb(1'b0, OFS_ACCR, 32'h0);
         if (s != 0) `CHK("acc_rd", 32'h5a5a_0f0f, rd)
      end
      `CHK("acc_wd", 32'hcafe_0001, acc_wdata_o)
      `CHK("trap_op", 16'h0, sub_data_o)
      $display("Test host access done");
      summarize();
   end
endmodule : ebtm_core_tb
`default_nettype wire
